// File: pkg/dmp_pkg.sv
package dmp_pkg;
    // operating mode codes on op_mode_i
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STDBY = 3'h1;
    localparam logic [2:0] MODE_FS = 3'h2;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_RX = 3'h4;

    // bit clock timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned BIT_PERIOD_NS = 400;
    localparam int unsigned HALF_CYC = BIT_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);

    // packet framing
    localparam logic [7:0] PRE_PATTERN = 8'hAA;
    localparam logic [1:0] PRE_BYTES = 2'h3;
    localparam logic [1:0] SYNC_BYTES = 2'h2;
    localparam logic [7:0] AES_MAX_FIXED = 8'h41;
    localparam logic [7:0] AES_MAX_VAR = 8'h41;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [11:0] MAP_RST = 12'h000;

    // host register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TXWORD = 8'h04;
    localparam logic [7:0] REG_RXWORD = 8'h08;
    localparam logic [7:0] REG_LINES = 8'h0C;
    localparam int unsigned CTRL_DRIVE_BIT = 0;
    localparam int unsigned CTRL_RXCLR_BIT = 1;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    typedef struct packed {
        logic mode_settled_flag;
        logic auto_sequencer_active;
        logic ref_clock_output;
        logic synth_locked_flag;
        logic receiver_ready_flag;
        logic transmitter_ready_flag;
        logic sync_match_flag;
        logic timeout_flag;
        logic rssi_flag;
        logic buffer_full_flag;
        logic buffer_nonempty_flag;
        logic buffer_threshold_flag;
        logic checksum_good_flag;
        logic payload_available_flag;
    } dmp_status_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_PRE = 7'h02,
        ST_SYNC = 7'h04,
        ST_LEN = 7'h08,
        ST_PAY = 7'h10,
        ST_CRC = 7'h20,
        ST_TAIL = 7'h40
    } dmp_state_t;
endpackage

// File: pkg/dmp_link_if.sv
`timescale 1ns/1ps
interface dmp_link_if;
    logic [5:0] dev_line;
    logic dev_data_oe;
    logic host_data;
    logic host_data_oe;
    logic data_wire;

    // device drive wins if both ends enable at once
    assign data_wire = dev_data_oe ? dev_line[2] : (host_data_oe & host_data);

    modport dev (output dev_line, output dev_data_oe, input data_wire);
    modport host (input dev_line, input data_wire, output host_data, output host_data_oe);
endinterface

// File: hdl/dmp_shifter.sv
`timescale 1ns/1ps
module dmp_shifter
    import dmp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [7:0] byte_i,
    output logic ready_o,
    output logic bit_o,
    output logic done_o
);
    logic [7:0] sr_ff;
    logic [3:0] cnt_ff;
    logic bit_ff;
    logic done_ff;
    wire busy = (cnt_ff != 4'h0);
    wire shift = busy & tick_i;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sr_ff <= 8'h00;
            cnt_ff <= 4'h0;
            bit_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce_i) begin
            done_ff <= shift & (cnt_ff == 4'h1);
            if (load_i & ~busy) begin
                sr_ff <= byte_i;
                cnt_ff <= 4'h8;
            end else if (shift) begin
                // msb first
                bit_ff <= sr_ff[7];
                sr_ff <= {sr_ff[6:0], 1'b0};
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end

    assign ready_o = ~busy;
    assign bit_o = bit_ff;
    assign done_o = done_ff;
endmodule // dmp_shifter

// File: hdl/dmp_dev.sv
`timescale 1ns/1ps
module dmp_dev
    import dmp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [2:0] op_mode_i,
    input wire logic pkt_mode_i,
    input wire logic bitsync_en_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] map1_i,
    input wire logic [7:0] map2_i,
    input wire dmp_status_t status_i,
    input wire logic demod_bit_i,
    input wire logic format_select_bit_i,
    input wire logic [7:0] programmed_length_i,
    input wire logic crc_en_i,
    input wire logic aes_en_i,
    input wire logic [15:0] sync_word_i,
    input wire logic [7:0] pay_data_i,
    input wire logic pay_valid_i,
    output logic pay_ready_o,
    output logic mod_bit_o,
    output logic mod_stb_o,
    output logic packet_done_flag_o,
    output logic len_err_o,
    dmp_link_if.dev link
);
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic map_line(input logic [2:0] ln, input logic [1:0] cd,
        input logic pk, input logic [2:0] md, input dmp_status_t s,
        input logic dk, input logic dt, input logic pd);
        logic rx;
        logic tx;
        logic fs;
        logic trx;
        logic nsl;
        logic r;
        rx = (md == MODE_RX);
        tx = (md == MODE_TX);
        fs = (md == MODE_FS);
        trx = rx | tx;
        nsl = (md != MODE_SLEEP);
        r = 1'b0;
        case ({pk, cd, ln})
            // continuous mode
            6'b0_00_000: r = (fs | tx) ? s.synth_locked_flag : rx & s.sync_match_flag;
            6'b0_00_001: r = trx & dk;
            6'b0_00_010, 6'b0_01_010, 6'b0_10_010, 6'b0_11_010: r = trx & dt;
            6'b0_00_011: r = rx ? s.rssi_flag : tx & s.transmitter_ready_flag;
            6'b0_00_100, 6'b0_01_000:
                r = rx ? s.timeout_flag : tx & s.transmitter_ready_flag;
            6'b0_00_101, 6'b1_00_101: r = nsl & s.ref_clock_output;
            6'b0_01_001, 6'b0_01_011, 6'b0_01_100:
                r = rx ? s.receiver_ready_flag : tx & s.transmitter_ready_flag;
            6'b0_01_101: r = rx ? s.rssi_flag : tx & s.ref_clock_output;
            6'b0_10_000: r = rx & s.rssi_flag;
            6'b0_10_011, 6'b1_11_010: r = s.auto_sequencer_active;
            6'b0_10_100: r = rx & s.sync_match_flag;
            6'b0_11_000, 6'b0_11_101, 6'b1_11_101: r = s.mode_settled_flag;
            6'b0_11_001: r = rx ? s.sync_match_flag : (fs | tx) & s.synth_locked_flag;
            6'b0_11_011: r = rx ? s.timeout_flag : tx & s.transmitter_ready_flag;
            6'b0_11_100, 6'b1_11_011, 6'b1_11_100: r = (fs | trx) & s.synth_locked_flag;
            // packet mode
            6'b1_00_000: r = rx ? s.checksum_good_flag : tx & pd;
            6'b1_00_001: r = s.buffer_threshold_flag;
            6'b1_00_010, 6'b1_10_001: r = s.buffer_nonempty_flag;
            6'b1_00_011, 6'b1_01_001: r = s.buffer_full_flag;
            6'b1_00_100: r = rx ? s.timeout_flag : tx & s.mode_settled_flag;
            6'b1_01_000: r = rx ? s.payload_available_flag : tx & s.transmitter_ready_flag;
            6'b1_01_010, 6'b1_01_101: r = trx & dt;
            6'b1_01_011, 6'b1_01_100: r = rx ? s.rssi_flag : tx & s.transmitter_ready_flag;
            6'b1_10_000, 6'b1_10_011: r = rx & s.sync_match_flag;
            6'b1_10_100: r = rx & s.receiver_ready_flag;
            6'b1_11_000: r = rx ? s.rssi_flag : (fs | tx) & s.synth_locked_flag;
            6'b1_11_001: r = rx ? s.timeout_flag : (fs | tx) & s.synth_locked_flag;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    logic [11:0] codes_ff;
    logic [5:0] gp_ff;
    logic oe_ff;
    logic d_s1_ff;
    logic d_s2_ff;
    logic [3:0] div_ff;
    logic dclk_ff;
    logic bs_data_ff;
    logic rdy_prev_ff;
    logic pay_prev_ff;
    logic rxwin_ff;
    logic mod_bit_ff;
    logic mod_stb_ff;
    logic live_ff;
    dmp_state_t st_ff;
    logic [1:0] cnt_ff;
    logic [7:0] len_ff;
    logic [7:0] hold_ff;
    logic hold_empty_ff;
    logic pay_rdy_ff;
    logic [15:0] crc_ff;
    logic done_ff;
    logic err_ff;
    logic sh_ready;
    logic sh_bit;
    logic sh_done;

    wire is_tx = (op_mode_i == MODE_TX);
    wire is_rx = (op_mode_i == MODE_RX);
    wire run_clk = is_tx | is_rx;
    wire cont_tx = ~pkt_mode_i & is_tx;
    wire pkt_tx = pkt_mode_i & is_tx;
    wire bs_on = bitsync_en_i | pkt_mode_i;
    wire div_end = run_clk & (div_ff == HALF_LAST);
    wire rise_ev = div_end & ~dclk_ff;
    wire fall_ev = div_end & dclk_ff;
    wire busy = (st_ff != ST_IDLE) & (st_ff != ST_TAIL);
    wire rdy_rise = status_i.receiver_ready_flag & ~rdy_prev_ff;
    wire pay_rise = status_i.payload_available_flag & ~pay_prev_ff;
    wire [11:0] nxt_codes = {map2_i[5:4], map2_i[7:6], map1_i[1:0],
                             map1_i[3:2], map1_i[5:4], map1_i[7:6]};
    // raw demodulator bit when unsynced, no clock then unless transmitting
    wire rx_data = bs_on ? bs_data_ff : demod_bit_i;
    wire line_clk = (is_tx | bs_on) & dclk_ff;
    wire pkt_rx_data = rxwin_ff & bs_data_ff;
    wire line_data = pkt_mode_i ? (is_tx ? sh_bit : pkt_rx_data) : rx_data;
    wire fix_bad = (programmed_length_i == 8'h00)
                   | (aes_en_i & (programmed_length_i > AES_MAX_FIXED));
    wire len_bad = (hold_ff == 8'h00)
                   | (aes_en_i & (hold_ff > AES_MAX_VAR));
    wire start = pkt_tx & (st_ff == ST_IDLE) & ~hold_empty_ff
                 & (format_select_bit_i | ~fix_bad);
    wire need_hold = (st_ff == ST_LEN) | (st_ff == ST_PAY);
    wire load = sh_ready & busy & ~(need_hold & hold_empty_ff);
    wire take = load & need_hold;
    // take a byte only where the sender saw ready high, never in the release cycle
    wire accept = pkt_mode_i & pay_rdy_ff & pay_valid_i;
    wire [7:0] tx_byte = (st_ff == ST_PRE) ? PRE_PATTERN
                       : (st_ff == ST_SYNC) ? (cnt_ff == 2'h0 ? sync_word_i[15:8]
                                                              : sync_word_i[7:0])
                       : (st_ff == ST_CRC) ? (cnt_ff == 2'h0 ? crc_ff[15:8] : crc_ff[7:0])
                       : hold_ff;
    logic [5:0] nxt_lines;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            nxt_lines[i] = map_line(3'(i), codes_ff[2*i+:2], pkt_mode_i, op_mode_i,
                                    status_i, line_clk, line_data, done_ff);
        end
    end

    dmp_shifter u_shift (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .tick_i(fall_ev),
        .load_i(load),
        .byte_i(tx_byte),
        .ready_o(sh_ready),
        .bit_o(sh_bit),
        .done_o(sh_done)
    );

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            codes_ff <= MAP_RST;
            gp_ff <= 6'h00;
            oe_ff <= 1'b0;
            d_s1_ff <= 1'b0;
            d_s2_ff <= 1'b0;
            rdy_prev_ff <= 1'b0;
            pay_prev_ff <= 1'b0;
            rxwin_ff <= 1'b0;
        end else if (ce_i) begin
            if (cfg_wr_i) codes_ff <= nxt_codes;
            gp_ff <= nxt_lines;
            // host owns the data line only in continuous transmit
            oe_ff <= ~cont_tx;
            d_s1_ff <= link.data_wire;
            d_s2_ff <= d_s1_ff;
            rdy_prev_ff <= status_i.receiver_ready_flag;
            pay_prev_ff <= status_i.payload_available_flag;
            if (rdy_rise) rxwin_ff <= 1'b1;
            else if (pay_rise | ~is_rx) rxwin_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            div_ff <= 4'h0;
            dclk_ff <= 1'b0;
            bs_data_ff <= 1'b0;
            mod_bit_ff <= 1'b0;
            mod_stb_ff <= 1'b0;
            live_ff <= 1'b0;
        end else if (ce_i) begin
            // divider halts low outside rx and tx, so no stray edges
            div_ff <= (div_end | ~run_clk) ? 4'h0 : div_ff + 4'h1;
            dclk_ff <= run_clk & (dclk_ff ^ div_end);
            if (fall_ev) bs_data_ff <= demod_bit_i;
            mod_stb_ff <= rise_ev & (cont_tx | (pkt_tx & live_ff));
            // a frame bit counts once shifted out, so the last strobe trails the frame
            if (~pkt_tx | (rise_ev & (st_ff == ST_IDLE))) live_ff <= 1'b0;
            else if (fall_ev & ~sh_ready) live_ff <= 1'b1;
            if (rise_ev) mod_bit_ff <= cont_tx ? d_s2_ff : sh_bit;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_ff <= ST_IDLE;
            cnt_ff <= 2'h0;
            len_ff <= 8'h00;
            hold_ff <= 8'h00;
            hold_empty_ff <= 1'b1;
            pay_rdy_ff <= 1'b0;
            crc_ff <= CRC_INIT;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (ce_i) begin
            if (accept) hold_ff <= pay_data_i;
            hold_empty_ff <= take | (hold_empty_ff & ~accept);
            pay_rdy_ff <= pkt_mode_i & (take | (hold_empty_ff & ~accept));
            if (take) crc_ff <= crc_upd(crc_ff, hold_ff);
            if (load) cnt_ff <= cnt_ff + 2'h1;
            // done is set by hardware and wins over the clear on a new start
            if (st_ff == ST_TAIL & sh_done) done_ff <= 1'b1;
            else if (start | ~pkt_tx) done_ff <= 1'b0;
            if (pkt_tx & (st_ff == ST_IDLE) & ~hold_empty_ff & ~format_select_bit_i)
                err_ff <= fix_bad;
            if (~pkt_tx) begin
                st_ff <= ST_IDLE; // framer idle outside packet transmit
            end else begin
                case (st_ff)
                    ST_IDLE: if (start) begin
                        st_ff <= ST_PRE;
                        cnt_ff <= 2'h0;
                        crc_ff <= CRC_INIT;
                    end
                    ST_PRE: if (load & cnt_ff == PRE_BYTES - 2'h1) begin
                        st_ff <= ST_SYNC;
                        cnt_ff <= 2'h0;
                    end
                    ST_SYNC: if (load & cnt_ff == SYNC_BYTES - 2'h1) begin
                        st_ff <= format_select_bit_i ? ST_LEN : ST_PAY;
                        len_ff <= programmed_length_i;
                    end
                    ST_LEN: if (take) begin
                        len_ff <= hold_ff;
                        err_ff <= len_bad;
                        st_ff <= len_bad ? ST_IDLE : ST_PAY;
                    end
                    ST_PAY: if (take) begin
                        len_ff <= len_ff - 8'h01;
                        cnt_ff <= 2'h0;
                        if (len_ff == 8'h01) st_ff <= crc_en_i ? ST_CRC : ST_TAIL;
                    end
                    ST_CRC: if (load & cnt_ff == 2'h1) st_ff <= ST_TAIL;
                    ST_TAIL: if (sh_done) st_ff <= ST_IDLE;
                    default: st_ff <= ST_IDLE;
                endcase
            end
        end
    end

    assign link.dev_line = gp_ff;
    assign link.dev_data_oe = oe_ff;
    assign pay_ready_o = pay_rdy_ff;
    assign mod_bit_o = mod_bit_ff;
    assign mod_stb_o = mod_stb_ff;
    assign packet_done_flag_o = done_ff;
    assign len_err_o = err_ff;
endmodule // dmp_dev

// File: hdl/dmp_host.sv
`timescale 1ns/1ps
module dmp_host
    import dmp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    dmp_link_if.host link
);
    logic [5:0] ln_s1_ff;
    logic [5:0] ln_s2_ff;
    logic dw_s1_ff;
    logic dw_s2_ff;
    logic dk_prev_ff;
    logic drive_ff;
    logic data_ff;
    logic [31:0] tx_sr_ff;
    logic [31:0] rx_sr_ff;
    logic [5:0] rx_cnt_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    wire acc = psel_i & penable_i;
    wire commit = acc & pready_ff & pwrite_i;
    wire hit_ctrl = (paddr_i == REG_CTRL);
    wire hit_tx = (paddr_i == REG_TXWORD);
    wire hit_rx = (paddr_i == REG_RXWORD);
    wire hit_ln = (paddr_i == REG_LINES);
    wire mapped = hit_ctrl | hit_tx | hit_rx | hit_ln;
    wire [31:0] rd_data = hit_ctrl ? {31'h0, drive_ff}
                        : hit_tx ? tx_sr_ff
                        : hit_rx ? rx_sr_ff
                        : hit_ln ? {18'h0, rx_cnt_ff, 2'h0, ln_s2_ff}
                        : 32'h0000_0000;
    wire dk_rise = ln_s2_ff[1] & ~dk_prev_ff;
    wire wr_ctrl = commit & hit_ctrl;
    wire wr_tx = commit & hit_tx;
    wire rx_clr = wr_ctrl & pwdata_i[CTRL_RXCLR_BIT];
    wire [31:0] rx_base = rx_clr ? WORD_RST : rx_sr_ff;
    wire [5:0] cnt_base = rx_clr ? 6'h00 : rx_cnt_ff;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ln_s1_ff <= 6'h00;
            ln_s2_ff <= 6'h00;
            dw_s1_ff <= 1'b0;
            dw_s2_ff <= 1'b0;
            dk_prev_ff <= 1'b0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= WORD_RST;
        end else if (ce_i) begin
            ln_s1_ff <= link.dev_line;
            ln_s2_ff <= ln_s1_ff;
            dw_s1_ff <= link.data_wire;
            dw_s2_ff <= dw_s1_ff;
            dk_prev_ff <= ln_s2_ff[1];
            // one wait state: answer prepared, then committed on the ready edge
            pready_ff <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & ~mapped;
            prdata_ff <= (acc & ~pready_ff & ~pwrite_i) ? rd_data : WORD_RST;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            drive_ff <= 1'b0;
            data_ff <= 1'b0;
            tx_sr_ff <= WORD_RST;
            rx_sr_ff <= WORD_RST;
            rx_cnt_ff <= 6'h00;
        end else if (ce_i) begin
            if (wr_ctrl) drive_ff <= pwdata_i[CTRL_DRIVE_BIT];
            if (wr_tx) begin
                tx_sr_ff <= pwdata_i;
                data_ff <= pwdata_i[31];
            end else if (dk_rise & drive_ff) begin
                // next bit only after the device clock rose
                data_ff <= tx_sr_ff[30];
                tx_sr_ff <= {tx_sr_ff[30:0], 1'b0};
            end
            // a bit landing with a clear is kept
            if (dk_rise & ~drive_ff) begin
                rx_sr_ff <= {rx_base[30:0], dw_s2_ff};
                rx_cnt_ff <= cnt_base + 6'h01;
            end else begin
                rx_sr_ff <= rx_base;
                rx_cnt_ff <= cnt_base;
            end
        end
    end

    assign link.host_data = data_ff;
    assign link.host_data_oe = drive_ff;
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
endmodule // dmp_host

// File: tb/dmp_link_properties.sv
`timescale 1ns/1ps
module dmp_link_properties
    import dmp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [5:0] dev_line,
    input wire logic dev_data_oe,
    input wire logic [2:0] op_mode_i,
    input wire logic pkt_mode_i,
    input wire logic bitsync_en_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] map1_i,
    input wire logic [7:0] map2_i,
    input wire dmp_status_t status_i,
    input wire logic demod_bit_i
);
    // mirror of the line codes, line0 in [11:10] down to line5 in [1:0]
    logic [11:0] code_ff;
    wire rx = op_mode_i == MODE_RX;
    wire c_tx = !pkt_mode_i && op_mode_i == MODE_TX;
    wire c_raw = !pkt_mode_i && rx && !bitsync_en_i;
    wire c_syn = !pkt_mode_i && rx && bitsync_en_i;
    wire k1 = code_ff[9:8] == 2'h0;
    wire ck = c_tx && k1;
    wire [2:0] fifo3 = {status_i.buffer_full_flag, status_i.buffer_nonempty_flag,
        status_i.buffer_threshold_flag};
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            code_ff <= MAP_RST;
        end else if (cfg_wr_i) begin
            code_ff <= {map1_i, map2_i[7:4]};
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_raw_data: assert property (c_raw |=> dev_line[2] == $past(demod_bit_i))
        else $error("raw data missing on line 2");
    a_raw_noclk: assert property (c_raw && k1 |=> !dev_line[1])
        else $error("bit clock seen in raw receive");
    a_tx_oe: assert property ((c_tx) [*2] |-> !dev_data_oe)
        else $error("device drives data in transmit");
    a_dclk_half: assert property (ck && $rose(dev_line[1]) |=>
        (dev_line[1] || !ck) [*7] ##1 (!dev_line[1] || !ck))
        else $error("bit clock high phase wrong");
    // data may only move while the clock is low, so it is steady at the rise
    a_syn_fall: assert property (c_syn && k1 && $past(k1) && $past(c_syn, 2) &&
        $changed(dev_line[2]) |-> !dev_line[1])
        else $error("synced data changed with clock high");
    a_mode_rdy: assert property (!pkt_mode_i && code_ff[11:10] == 2'h3 &&
        code_ff[1:0] == 2'h3 |=> dev_line[0] == $past(status_i.mode_settled_flag)
        && dev_line[5] == dev_line[0])
        else $error("mode ready not on lines 0 and 5");
    a_unmapped_low: assert property (!pkt_mode_i && op_mode_i == MODE_SLEEP &&
        code_ff == 12'h000 |=> dev_line == 6'h00)
        else $error("unmapped line not low");
    a_pkt_fifo: assert property (pkt_mode_i && code_ff[9:4] == 6'h00 |=>
        dev_line[3:1] == $past(fifo3))
        else $error("buffer flags not on lines 1 to 3");
    a_pkt_crc: assert property (pkt_mode_i && rx && code_ff[11:10] == 2'h0 |=>
        dev_line[0] == $past(status_i.checksum_good_flag))
        else $error("checksum flag not on line 0");
    c_dclk: cover property (ck && $rose(dev_line[1]));
    c_sync: cover property (c_syn && k1 && $fell(dev_line[1]));
    c_sent: cover property (pkt_mode_i && op_mode_i == MODE_TX && dev_line[0]);
endmodule // dmp_link_properties

// File: tb/dio_map_and_packet_format_tb.sv
`timescale 1ns/1ps
module dio_map_and_packet_format_tb;
    import dmp_pkg::*;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, cfg_wr = 1'b0, pkt = 1'b0, bsync = 1'b0;
    logic demod = 1'b0, fmt = 1'b0, aes = 1'b0, pval = 1'b0, psel = 1'b0, pen = 1'b0;
    logic pwr = 1'b0, pay_rdy, mbit, mstb, pdone, lerr, pready, pslverr;
    logic [2:0] op = MODE_STDBY;
    logic [7:0] map1 = 8'h00, map2 = 8'h00, plen = 8'h00, pdat = 8'h00, paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h52, w;
    dmp_status_t stat = '0;
    int num_errors = 0, n_checks = 0;
    logic [32:0] apb_q[$];
    logic bit_q[$];
    dmp_link_if link();
    dmp_dev i_dmp_dev (.clk_sys_i, .sys_rst_i, .ce_i(1'b1), .op_mode_i(op), .pkt_mode_i(pkt),
        .bitsync_en_i(bsync), .cfg_wr_i(cfg_wr), .map1_i(map1), .map2_i(map2), .status_i(stat),
        .demod_bit_i(demod), .format_select_bit_i(fmt), .programmed_length_i(plen),
        .crc_en_i(1'b0), .aes_en_i(aes), .sync_word_i(16'hC3A5), .pay_data_i(pdat),
        .pay_valid_i(pval), .pay_ready_o(pay_rdy), .mod_bit_o(mbit), .mod_stb_o(mstb),
        .packet_done_flag_o(pdone), .len_err_o(lerr), .link(link.dev));
    dmp_host i_dmp_host (.clk_sys_i, .sys_rst_i, .ce_i(1'b1), .paddr_i(paddr), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .link(link.host));
    dmp_link_properties u_props (.clk_sys_i, .sys_rst_i, .dev_line(link.dev_line),
        .dev_data_oe(link.dev_data_oe), .op_mode_i(op), .pkt_mode_i(pkt), .bitsync_en_i(bsync),
        .cfg_wr_i(cfg_wr), .map1_i(map1), .map2_i(map2), .status_i(stat), .demod_bit_i(demod));
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    always @(posedge clk_sys_i) begin
        seed <= xs(seed);
        demod <= seed[9];
        if (psel && pen && pready === 1'b1 && apb_q.size() > 0)
            chk("apb", apb_q.pop_front(), {pslverr, prdata});
        if (mstb === 1'b1 && bit_q.size() > 0) chk("mod_bit", bit_q.pop_front(), mbit);
    end
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            num_errors++;
            $display("mismatch wait exp done got timeout");
            stop_test();
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int k;
        apb_q.push_back(e);
        @(posedge clk_sys_i);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk_sys_i);
        pen <= 1'b1;
        k = 0;
        do @(posedge clk_sys_i); while (pready !== 1'b1 && ++k < 50);
        bound(k, 50);
        {psel, pen} <= 2'b00;
    endtask
    // valid stays up between bytes; only the last byte of a burst drops it
    task automatic send(input logic [7:0] b, input logic last);
        int k;
        {pval, pdat} <= {1'b1, b};
        k = 0;
        do @(posedge clk_sys_i); while (pay_rdy !== 1'b1 && ++k < 2000);
        bound(k, 2000);
        if (last) pval <= 1'b0;
    endtask
    task automatic push8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_q.push_back(b[i]);
    endtask
    task automatic pkt_case(input int k);
        logic [7:0] ln;
        int j;
        ln = (k < 2) ? 8'h02 : ((k > 3) ? 8'h42 : 8'h00);
        w = seed;
        sys_rst_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        {sys_rst_i, fmt, aes, plen, pkt, op} <= {1'b0, k[0], k > 3, ln, 1'b1, MODE_STDBY};
        if (k < 2) for (j = 0; j < 3; j++) push8(PRE_PATTERN);
        if (k < 2) push8(8'hC3);
        if (k < 2) push8(8'hA5);
        if (k == 1) push8(ln);
        if (k < 2) push8(w[7:0]);
        if (k < 2) push8(w[15:8]);
        send(k[0] ? ln : w[7:0], k > 1);
        op <= MODE_TX;
        if (k == 1) send(w[7:0], 1'b0);
        if (k < 2) send(w[15:8], 1'b1);
        for (j = 0; j < 4000 && (k < 2 ? pdone : lerr) !== 1'b1; j++) @(posedge clk_sys_i);
        bound(j, 4000);
        chk("done_err", {k < 2, k > 1}, {pdone, lerr});
        // the last bit reaches the modulator within half a bit time after done
        repeat (20) @(posedge clk_sys_i);
        chk("bits_left", 33'h0, bit_q.size());
    endtask
    initial begin
        int i;
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        w = seed;
        apb(1'b1, REG_TXWORD, w, 33'h0);
        apb(1'b0, REG_TXWORD, 32'h0, {1'b0, w});
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
        apb(1'b1, REG_CTRL, 32'h1, 33'h0);
        for (i = 31; i >= 0; i--) bit_q.push_back(w[i]);
        op <= MODE_TX;
        for (i = 0; i < 2000 && bit_q.size() > 0; i++) @(posedge clk_sys_i);
        bound(i, 2000);
        op <= MODE_RX;
        repeat (200) @(posedge clk_sys_i);
        bsync <= 1'b1;
        repeat (400) @(posedge clk_sys_i);
        for (i = 0; i < 40; i++) begin
            {map1, map2, cfg_wr} <= {{6{i[1:0]}}, 4'h0, 1'b1};
            {pkt, op} <= {i[2], 3'(i / 8)};
            repeat (6) begin
                @(posedge clk_sys_i);
                {cfg_wr, stat} <= {1'b0, seed[13:0]};
            end
            repeat (2) @(posedge clk_sys_i);
            if (i[2:0] == 3'h3)
                chk("line0", stat.mode_settled_flag, link.dev_line[0]);
        end
        for (i = 0; i < 6; i++) pkt_case(i);
        stop_test();
    end
endmodule // dio_map_and_packet_format_tb
